// >>> wdt_defines.svh
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_OPT_ADDR 16'h0080
`define WDT_KEY_ADDR 16'hff99
`define WDT_KEY 8'hac
`define WDT_RST_EN 8'h9a
`define WDT_RST_DIS 8'h1a
`define WDT_WIN_HI 6
`define WDT_WIN_LO 5
`define WDT_ENA_BIT 4
`define WDT_OVF_MSB 3
`define WDT_OVF_LSB 1
`define WDT_LOCK_BIT 0
`define WDT_CNT_W 17
`define WDT_OVF_BASE 5'h0a
`define WDT_QTR_BASE 5'h08
`define WDT_FREE_LO 16'hfb00
`endif

// >>> wdt_pkg.sv
package wdt_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic bit_op;
   } wdt_bus_t;
   typedef struct packed {
      logic window_select_high;
      logic window_select_low;
      logic counter_enable_option;
      logic [2:0] overflow_select;
      logic lowspeed_osc_lock;
   } wdt_opt_t;
   typedef enum logic [1:0] {
      WDT_FIRST = 2'b00,
      WDT_RUN = 2'b01,
      WDT_TRIP = 2'b11
   } wdt_state_t;
   typedef enum logic [2:0] {
      CAUSE_NONE = 3'h0,
      CAUSE_OVF = 3'h1,
      CAUSE_KEY = 3'h2,
      CAUSE_BIT = 3'h3,
      CAUSE_WIN = 3'h4,
      CAUSE_FETCH = 3'h5,
      CAUSE_DATA = 3'h6
   } wdt_cause_t;
endpackage

// >>> wdt_ls_tick.sv
`timescale 1ns/10ps
module wdt_ls_tick (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic ls_clk_pin,
   output logic tick
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic tick_q;
   logic tick_d;
   always_comb begin
      sh_d = {sh_q[1:0], ls_clk_pin};
      // edge seen between second and third stage only
      tick_d = sh_q[1] & ~sh_q[2];
      if (sys_rst) begin
         // keep tracking the pin so a high level at release is no edge
         tick_d = 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      sh_q <= sh_d;
      tick_q <= tick_d;
   end
   assign tick = tick_q;
endmodule // wdt_ls_tick

// >>> wdt_access_chk.sv
`timescale 1ns/10ps
`include "wdt_defines.svh"
module wdt_access_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic data_valid,
   input wire logic [15:0] data_addr,
   input wire logic [15:0] code_limit,
   input wire logic [15:0] ram_base,
   output logic fetch_err,
   output logic data_err
);
   logic fetch_err_q;
   logic fetch_err_d;
   logic data_err_q;
   logic data_err_d;
   logic fetch_ok;
   logic data_ok;
   always_comb begin
      fetch_ok = (fetch_addr < code_limit) || (fetch_addr >= ram_base);
      // the top area is always legal for data, never widened for fetch
      data_ok = (data_addr < code_limit) || (data_addr >= ram_base) ||
                (data_addr >= `WDT_FREE_LO);
      fetch_err_d = enable && fetch_valid && !fetch_ok;
      data_err_d = enable && data_valid && !data_ok;
      if (sys_rst) begin
         fetch_err_d = 1'b0;
         data_err_d = 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      fetch_err_q <= fetch_err_d;
      data_err_q <= data_err_d;
   end
   assign fetch_err = fetch_err_q;
   assign data_err = data_err_q;
endmodule // wdt_access_chk

// >>> wdt_top.sv
// Function
// - key write clears counter and restarts counting when the write is legal
// - clear register reset value is 9AH when enabled, 1AH when disabled
// - any non-key value written to clear register requests internal reset
// - single-bit operation on clear register requests internal reset
// - illegal write while source clock stopped resets once clock resumes
// - reading clear register returns its reset value, never the key
// - enable option starts counting and access checks; otherwise both stay off
// - reaching overflow without valid key write requests internal reset
// - first write after reset clears counter regardless of window
// - later writes in closed window request reset, even a correct key
// - key write in open window clears and restarts counter
// - overflow time is 2^(10+code) low-speed periods
// - window code picks open fraction 25, 50, 75 or 100 percent
// - closed window covers interval start; open part runs to overflow
// - clear is accepted up to the last count before overflow
// - time to overflow after a key write is within two periods
// - without lock, counting freezes in halt and stop and resumes held
// - without lock, stopping the low-speed oscillator freezes the count
// - counting continues during flash self-programming and emulation
// - fetch outside configured area requests reset while checks enabled
// - data access outside area, except FB00H-FFFFH, requests reset
// - counter advances on the internal low-speed oscillation clock
// - any watchdog reset sets the watchdog reset flag
`timescale 1ns/10ps
`include "wdt_defines.svh"
module wdt_top
   import wdt_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic lowspeed_osc_clk,
   input wire logic [7:0] option_byte,
   input wdt_bus_t bus,
   output logic [7:0] rdata,
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic lowspeed_osc_stop,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic data_valid,
   input wire logic [15:0] data_addr,
   input wire logic [15:0] code_limit,
   input wire logic [15:0] ram_base,
   output logic wdt_reset_req,
   output logic watchdog_reset_flag,
   output wdt_cause_t reset_cause
);
   localparam int CW = `WDT_CNT_W;

   logic [7:0] opt_raw_q;
   logic [7:0] opt_raw_d;
   wdt_opt_t opt;
   logic ls_tick;
   logic clk_running;
   logic src_tick;
   logic count_tick;
   logic fetch_err;
   logic data_err;

   wdt_state_t state_q;
   wdt_state_t state_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   wdt_cause_t pend_q;
   wdt_cause_t pend_d;
   wdt_cause_t cause_q;
   wdt_cause_t cause_d;
   logic flag_q;
   logic flag_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   logic [CW-1:0] cnt_last;
   logic [CW-1:0] qtr;
   logic [CW-1:0] closed_lim;
   logic closed;
   logic key_wr;
   logic key_rd;
   logic legal_clear;
   wdt_cause_t wr_fault;
   logic [7:0] key_reset_val;

   // option byte: captured throughout reset, frozen once it is released
   always_comb begin
      opt_raw_d = opt_raw_q;
      if (sys_rst) begin
         opt_raw_d = option_byte;
      end
   end
   always_ff @(posedge clock) begin
      opt_raw_q <= opt_raw_d;
   end

   assign opt.window_select_high = opt_raw_q[`WDT_WIN_HI];
   assign opt.window_select_low = opt_raw_q[`WDT_WIN_LO];
   assign opt.counter_enable_option = opt_raw_q[`WDT_ENA_BIT];
   assign opt.overflow_select = opt_raw_q[`WDT_OVF_MSB:`WDT_OVF_LSB];
   assign opt.lowspeed_osc_lock = opt_raw_q[`WDT_LOCK_BIT];

   wdt_ls_tick u_tick (
      .clock(clock),
      .sys_rst(sys_rst),
      .ls_clk_pin(lowspeed_osc_clk),
      .tick(ls_tick)
   );

   wdt_access_chk u_acc (
      .clock(clock),
      .sys_rst(sys_rst),
      .enable(opt.counter_enable_option),
      .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr),
      .data_valid(data_valid),
      .data_addr(data_addr),
      .code_limit(code_limit),
      .ram_base(ram_base),
      .fetch_err(fetch_err),
      .data_err(data_err)
   );

   // flash self-programming has no input here on purpose: it never pauses us
   always_comb begin
      clk_running = opt.lowspeed_osc_lock ||
                    !(halt_mode || stop_mode || lowspeed_osc_stop);
      src_tick = ls_tick && clk_running;
      count_tick = src_tick && opt.counter_enable_option;
   end

   // interval geometry from the overflow and window codes
   always_comb begin
      cnt_last = CW'((18'h1 << (`WDT_OVF_BASE + 5'(opt.overflow_select))) - 18'h1);
      qtr = CW'(18'h1 << (`WDT_QTR_BASE + 5'(opt.overflow_select)));
      case ({opt.window_select_high, opt.window_select_low})
         2'b00: closed_lim = CW'(qtr + (qtr << 1));
         2'b01: closed_lim = CW'(qtr << 1);
         2'b10: closed_lim = qtr;
         2'b11: closed_lim = '0;
         default: closed_lim = '0;
      endcase
      // code 000 with 25% is left unguarded; software must avoid it
      closed = cnt_q < closed_lim;
   end

   // clear register access decode
   always_comb begin
      key_wr = bus.wr && (bus.addr == `WDT_KEY_ADDR);
      key_rd = bus.rd && (bus.addr == `WDT_KEY_ADDR);
      key_reset_val = opt.counter_enable_option ? `WDT_RST_EN : `WDT_RST_DIS;
      wr_fault = CAUSE_NONE;
      if (key_wr) begin
         if (bus.bit_op) begin
            wr_fault = CAUSE_BIT;
         end else if (bus.wdata != `WDT_KEY) begin
            wr_fault = CAUSE_KEY;
         end else if (state_q == WDT_RUN && closed) begin
            wr_fault = CAUSE_WIN;
         end
      end
      // first write ignores the window; accepted through the last count
      legal_clear = key_wr && (wr_fault == CAUSE_NONE) &&
                    (state_q != WDT_TRIP);
   end

   // main sequence: counter, deferred faults, trip
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      pend_d = pend_q;
      cause_d = cause_q;
      flag_d = 1'b0;
      if (state_q != WDT_TRIP) begin
         if (legal_clear) begin
            // clearing on the bus cycle keeps the overflow error within a tick
            cnt_d = '0;
            state_d = WDT_RUN;
         end else if (count_tick) begin
            cnt_d = CW'(cnt_q + 1'b1);
         end
         // write faults wait for a live source clock edge
         if (pend_q == CAUSE_NONE && wr_fault != CAUSE_NONE) begin
            pend_d = wr_fault;
         end
         if (fetch_err || data_err) begin
            state_d = WDT_TRIP;
            cause_d = fetch_err ? CAUSE_FETCH : CAUSE_DATA;
            flag_d = 1'b1;
         end else if (src_tick && pend_q != CAUSE_NONE) begin
            state_d = WDT_TRIP;
            cause_d = pend_q;
            flag_d = 1'b1;
         end else if (count_tick && !legal_clear && cnt_q == cnt_last) begin
            state_d = WDT_TRIP;
            cause_d = CAUSE_OVF;
            flag_d = 1'b1;
         end
      end
      if (sys_rst) begin
         state_d = WDT_FIRST;
         cnt_d = '0;
         pend_d = CAUSE_NONE;
         cause_d = CAUSE_NONE;
         flag_d = 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      cause_q <= cause_d;
      flag_q <= flag_d;
   end

   // read port: the key never reads back
   always_comb begin
      rdata_d = rdata_q;
      if (key_rd) begin
         rdata_d = key_reset_val;
      end else if (bus.rd && bus.addr == `WDT_OPT_ADDR) begin
         rdata_d = opt_raw_q;
      end else if (bus.rd) begin
         rdata_d = 8'h00;
      end
      if (sys_rst) begin
         rdata_d = 8'h00;
      end
   end
   always_ff @(posedge clock) begin
      rdata_q <= rdata_d;
   end

   assign rdata = rdata_q;
   // request held until the reset generator asserts sys_rst
   assign wdt_reset_req = (state_q == WDT_TRIP);
   assign watchdog_reset_flag = flag_q;
   assign reset_cause = cause_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   sequence seq_clear;
      legal_clear ##1 (cnt_q == '0 && state_q == WDT_RUN);
   endsequence

   sequence seq_trip;
      (state_q == WDT_TRIP) && flag_q;
   endsequence

   chk_key_clear: assert property (
      legal_clear && !$past(sys_rst) && !fetch_err && !data_err &&
      !(src_tick && pend_q != CAUSE_NONE) |-> seq_clear)
      else $error("key write did not clear counter");

   chk_read_value: assert property (
      key_rd |=> rdata_q == (opt.counter_enable_option ? 8'h9a : 8'h1a))
      else $error("clear register read wrong value");

   chk_bad_key: assert property (
      key_wr && !bus.bit_op && bus.wdata != 8'hac && state_q != WDT_TRIP
      |=> pend_q != CAUSE_NONE || state_q == WDT_TRIP)
      else $error("bad key not flagged");

   chk_bit_op: assert property (
      key_wr && bus.bit_op && state_q != WDT_TRIP
      |=> pend_q != CAUSE_NONE || state_q == WDT_TRIP)
      else $error("bit operation not flagged");

   chk_defer_fire: assert property (
      pend_q != CAUSE_NONE && src_tick && state_q != WDT_TRIP |=> seq_trip)
      else $error("pending fault not issued on tick");

   chk_defer_wait: assert property (
      pend_q != CAUSE_NONE && !src_tick && !fetch_err && !data_err &&
      state_q == WDT_RUN |=> state_q != WDT_TRIP)
      else $error("fault issued without source clock");

   chk_disabled: assert property (
      !opt.counter_enable_option |-> cnt_q == '0)
      else $error("counter ran while disabled");

   chk_overflow: assert property (
      count_tick && cnt_q == cnt_last && !legal_clear && state_q != WDT_TRIP
      |=> seq_trip ##1 (state_q == WDT_TRIP)[*2])
      else $error("overflow did not trip");

   chk_first_write: assert property (
      state_q == WDT_FIRST && key_wr && !bus.bit_op && bus.wdata == 8'hac &&
      !fetch_err && !data_err && !(src_tick && pend_q != CAUSE_NONE)
      |=> cnt_q == '0 && state_q == WDT_RUN)
      else $error("first key write rejected");

   chk_closed_write: assert property (
      state_q == WDT_RUN && key_wr && closed
      |=> pend_q != CAUSE_NONE || state_q == WDT_TRIP)
      else $error("closed window write accepted");

   chk_freeze: assert property (
      !opt.lowspeed_osc_lock && (halt_mode || stop_mode || lowspeed_osc_stop) &&
      !legal_clear |=> $stable(cnt_q))
      else $error("counter moved while frozen");

   chk_opt_hold: assert property (
      !sys_rst |=> $stable(opt_raw_q))
      else $error("option byte changed after reset");

   chk_access_trip: assert property (
      (fetch_err || data_err) && state_q != WDT_TRIP |=> seq_trip)
      else $error("access fault did not trip");

   chk_flag_once: assert property (
      $rose(wdt_reset_req) |-> flag_q ##1 !flag_q)
      else $error("reset flag not a single pulse");

   chk_access_off: assert property (
      !opt.counter_enable_option |-> !fetch_err && !data_err)
      else $error("access fault while detection disabled");

   chk_full_open: assert property (
      opt.window_select_high && opt.window_select_low |-> !closed)
      else $error("closed window at full open setting");

   chk_half_window: assert property (
      {opt.window_select_high, opt.window_select_low} == 2'b01 |->
      closed == (cnt_q < CW'(18'h1 << (`WDT_OVF_BASE - 5'h01 + 5'(opt.overflow_select)))))
      else $error("half window limit wrong");

   chk_lock_runs: assert property (
      opt.lowspeed_osc_lock && opt.counter_enable_option && ls_tick &&
      state_q != WDT_TRIP && !legal_clear && cnt_q != cnt_last
      |=> cnt_q == CW'($past(cnt_q) + 1'b1))
      else $error("locked counter did not advance");

   // open window key must pass the decode itself, not only clear afterwards
   chk_open_clear: assert property (
      state_q == WDT_RUN && key_wr && !bus.bit_op && bus.wdata == 8'hac && !closed &&
      !fetch_err && !data_err && !(src_tick && pend_q != CAUSE_NONE) |-> seq_clear)
      else $error("open window key not accepted");

   chk_trip_hold: assert property (
      state_q == WDT_TRIP |=> state_q == WDT_TRIP)
      else $error("reset request dropped before reset");

   chk_flag_cause: assert property (
      flag_q |-> wdt_reset_req && reset_cause != CAUSE_NONE)
      else $error("reset flag without a cause");
endmodule // wdt_top

// >>> wdt_partner.sv
`timescale 1ns/10ps
module wdt_partner #(
   parameter int LS_HALF_NS = 40
) (
   input wire logic clock,
   input wire logic lowspeed_osc_stop,
   input wire logic watchdog_reset_flag,
   input wire logic flag_clr,
   output logic lowspeed_osc_clk,
   output logic [7:0] reset_cause_register
);
   // stopped oscillator holds its level, so no stray edge on resume
   initial begin
      lowspeed_osc_clk = 1'b0;
      forever begin
         #(LS_HALF_NS);
         if (!lowspeed_osc_stop) begin
            lowspeed_osc_clk = ~lowspeed_osc_clk;
         end
      end
   end
   // bench clears the flag with each reset so every trip is seen afresh
   always_ff @(posedge clock) begin
      if (flag_clr) begin
         reset_cause_register <= 8'h00;
      end else if (watchdog_reset_flag) begin
         reset_cause_register[4] <= 1'b1;
      end
   end
endmodule // wdt_partner

// >>> tb_top.sv
`timescale 1ns/10ps
`include "wdt_defines.svh"
module tb_top
   import wdt_pkg::*;
;
   logic clock;
   logic sys_rst;
   logic [7:0] option_byte;
   wdt_bus_t bus;
   logic [7:0] rdata;
   logic halt_mode;
   logic stop_mode;
   logic lowspeed_osc_stop;
   logic lowspeed_osc_clk;
   logic fetch_valid;
   logic [15:0] fetch_addr;
   logic data_valid;
   logic [15:0] data_addr;
   logic [15:0] code_limit;
   logic [15:0] ram_base;
   logic wdt_reset_req;
   logic watchdog_reset_flag;
   wdt_cause_t reset_cause;
   logic [7:0] reset_cause_register;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_ls = 0;
   int t0 = 0;
   wdt_top uut (.clock(clock), .sys_rst(sys_rst), .lowspeed_osc_clk(lowspeed_osc_clk),
      .option_byte(option_byte), .bus(bus), .rdata(rdata), .halt_mode(halt_mode),
      .stop_mode(stop_mode), .lowspeed_osc_stop(lowspeed_osc_stop), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .data_valid(data_valid), .data_addr(data_addr),
      .code_limit(code_limit), .ram_base(ram_base), .wdt_reset_req(wdt_reset_req),
      .watchdog_reset_flag(watchdog_reset_flag), .reset_cause(reset_cause));
   wdt_partner #(.LS_HALF_NS(40)) env (.clock(clock), .lowspeed_osc_stop(lowspeed_osc_stop),
      .watchdog_reset_flag(watchdog_reset_flag), .flag_clr(sys_rst),
      .lowspeed_osc_clk(lowspeed_osc_clk), .reset_cause_register(reset_cause_register));
   always @(posedge lowspeed_osc_clk) n_ls <= n_ls + 1;
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic [7:0] opt(input logic [1:0] w, input logic e,
      input logic [2:0] c, input logic l);
      return {1'b0, w, e, c, l};
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wait_ls(input int n);
      repeat (n) @(posedge lowspeed_osc_clk);
      wait_clk(1);
   endtask
   task automatic start(input logic [7:0] o);
      wait_clk(1);
      sys_rst = 1'b1;
      option_byte = o;
      halt_mode = 1'b0;
      stop_mode = 1'b0;
      lowspeed_osc_stop = 1'b0;
      wait_clk(10);
      sys_rst = 1'b0;
      t0 = n_ls;
   endtask
   task automatic wr(input logic [7:0] d, input logic b);
      wait_clk(1);
      bus.addr = `WDT_KEY_ADDR;
      bus.wdata = d;
      bus.bit_op = b;
      bus.wr = 1'b1;
      wait_clk(1);
      bus = '0;
   endtask
   task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
      wait_clk(1);
      bus.addr = a;
      bus.rd = 1'b1;
      wait_clk(1);
      bus = '0;
      wait_clk(1);
      check(name, {8'h00, rdata}, {8'h00, exp});
   endtask
   task automatic acc(input logic f, input logic [15:0] a);
      wait_clk(1);
      fetch_valid = f;
      data_valid = !f;
      fetch_addr = a;
      data_addr = a;
      wait_clk(1);
      fetch_valid = 1'b0;
      data_valid = 1'b0;
   endtask
   task automatic idle(input string name);
      check(name, {15'h0, wdt_reset_req}, 16'h0000);
   endtask
   task automatic trip(input string name, input int max_cyc, input wdt_cause_t exp);
      int i;
      i = 0;
      while (wdt_reset_req !== 1'b1 && i < max_cyc) begin
         wait_clk(1);
         i++;
      end
      wait_clk(1);
      check(name, {13'h0, reset_cause}, {13'h0, exp});
      check("reset_flag", {8'h00, reset_cause_register}, 16'h0010);
   endtask
   task automatic ovf(input string name, input int n);
      logic ok;
      trip(name, n * 10 + 400, CAUSE_OVF);
      ok = (n_ls - t0 >= n - 2) && (n_ls - t0 <= n + 3);
      check("ovf_ticks", {15'h0, ok}, 16'h0001);
   endtask
   initial begin
      #950000;
      n_mismatch++;
      conclude();
   end
   initial begin
      sys_rst = 1'b1;
      option_byte = 8'h00;
      bus = '0;
      halt_mode = 1'b0;
      stop_mode = 1'b0;
      lowspeed_osc_stop = 1'b0;
      fetch_valid = 1'b0;
      data_valid = 1'b0;
      fetch_addr = 16'h0000;
      data_addr = 16'h0000;
      code_limit = 16'h8000;
      ram_base = 16'hfe00;
      start(opt(2'b01, 1'b1, 3'h0, 1'b0));
      option_byte = 8'h00;
      rd("clear_rd", `WDT_KEY_ADDR, `WDT_RST_EN);
      rd("opt_rd", `WDT_OPT_ADDR, opt(2'b01, 1'b1, 3'h0, 1'b0));
      rd("unmapped", 16'h1234, 8'h00);
      // first key lands in the closed part yet must still clear
      wait_ls(40);
      wr(`WDT_KEY, 1'b0);
      wait_ls(1019);
      idle("first_clear");
      wr(`WDT_KEY, 1'b0);
      rd("key_rd", `WDT_KEY_ADDR, `WDT_RST_EN);
      wait_ls(100);
      idle("late_clear");
      wr(`WDT_KEY, 1'b0);
      trip("closed_key", 200, CAUSE_WIN);
      start(opt(2'b11, 1'b1, 3'h0, 1'b1));
      halt_mode = 1'b1;
      stop_mode = 1'b1;
      ovf("ovf_locked", 1024);
      start(opt(2'b10, 1'b1, 3'h1, 1'b0));
      wait_ls(5);
      wr(`WDT_KEY, 1'b0);
      wait_ls(520);
      wr(`WDT_KEY, 1'b0);
      t0 = n_ls;
      ovf("ovf_after_key", 2048);
      for (int c = 0; c < 8; c++) begin
         start(opt(2'b01, 1'b1, 3'(c), 1'b0));
         wr(`WDT_KEY, 1'b0);
         wait_ls(3);
         wr(`WDT_KEY, 1'b0);
         trip("closed_code", 200, CAUSE_WIN);
      end
      for (int i = 0; i < 2; i++) begin
         start(opt(2'b00, 1'b1, 3'h1, 1'b0));
         wr(i ? `WDT_KEY : 8'h55, i[0]);
         trip("bad_write", 200, i ? CAUSE_BIT : CAUSE_KEY);
      end
      start(opt(2'b11, 1'b1, 3'h0, 1'b0));
      lowspeed_osc_stop = 1'b1;
      wr(8'h55, 1'b0);
      wait_clk(200);
      idle("held_fault");
      lowspeed_osc_stop = 1'b0;
      trip("resumed_fault", 200, CAUSE_KEY);
      start(opt(2'b11, 1'b0, 3'h0, 1'b0));
      rd("clear_rd_dis", `WDT_KEY_ADDR, `WDT_RST_DIS);
      acc(1'b1, 16'h9000);
      wait_ls(1100);
      idle("disabled");
      start(opt(2'b11, 1'b1, 3'h0, 1'b0));
      acc(1'b0, 16'hfc00);
      acc(1'b1, 16'h0100);
      acc(1'b0, 16'hfe10);
      wait_clk(5);
      idle("legal_acc");
      // the top area is free for data only, so a fetch there must trip
      acc(1'b1, 16'hfc00);
      trip("fetch_err", 20, CAUSE_FETCH);
      start(opt(2'b11, 1'b1, 3'h0, 1'b0));
      acc(1'b0, 16'h9000);
      trip("data_err", 20, CAUSE_DATA);
      // unlocked: halt, stop and a stopped oscillator each hold the count
      start(opt(2'b11, 1'b1, 3'h0, 1'b0));
      wait_ls(500);
      halt_mode = 1'b1;
      wait_ls(300);
      halt_mode = 1'b0;
      stop_mode = 1'b1;
      wait_ls(300);
      stop_mode = 1'b0;
      lowspeed_osc_stop = 1'b1;
      wait_clk(2000);
      idle("frozen");
      lowspeed_osc_stop = 1'b0;
      t0 = n_ls - 500;
      ovf("ovf_resumed", 1024);
      conclude();
   end
endmodule // tb_top
